// ---- src/pwr_seq_ctrl.sv ----
// Purpose : Power-up delay, halt and stop sequencing with interrupt registers
// Assumes : Instruction decode gives one-cycle halt/stop/ei/di pulses
// Notes   : Registers on a plain port, read data one cycle after read strobe
`timescale 1ns/1ps
module pwr_seq_ctrl #(
    parameter int RC_DIV    = 1250,
    parameter int POR_COUNT = pwr_seq_pkg::POR_TICKS
) (
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire logic [pwr_seq_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [pwr_seq_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [pwr_seq_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                            power_good,
    input  wire logic                            watchdog_timeout,
    input  wire logic                            stop_recovery,
    input  wire logic                            ext_reset,
    input  wire logic [pwr_seq_pkg::NUM_IRQ-1:0] irq_in,
    input  wire logic                            halt_instr,
    input  wire logic                            stop_instr,
    input  wire logic                            enable_ints_instr,
    input  wire logic                            disable_ints_instr,
    input  wire logic                            int_ack,
    output logic                                 cpu_reset,
    output logic                                 cpu_clk_en,
    output logic                                 xtal_en,
    output logic                                 periph_clk_en,
    output logic                                 int_take,
    output logic      [2:0]                      int_vector,
    output logic                                 restart_req,
    output logic      [15:0]                     restart_addr
);
    import pwr_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Checks and shared decode
    initial begin
        if (NUM_IRQ != 6) $error("Six interrupt sources expected");
        if (RC_DIV < 1) $error("RC_DIV must be positive");
    end

    // Lowest-numbered pending and enabled source wins
    function automatic logic [2:0] pick_irq(input logic [NUM_IRQ-1:0] p);
        logic [2:0] v;
        v = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (p[i]) v = 3'(i);
        end
        return v;
    endfunction

    typedef struct packed {
        logic [7:0]     irq_flags;
        logic [7:0]     int_mask;
        logic [7:0]     stop_recov;
        logic [DATA_W-1:0] rdata;
        pwr_state_t     st;
        logic           pg_prev;
        logic           cpu_reset;
        logic           cpu_clk_en;
        logic           xtal_en;
        logic           periph_clk_en;
        logic           int_take;
        logic [2:0]     int_vector;
        logic           restart_req;
    } ctl_t;
    ctl_t s_q, s_d;

    logic rc_tick;
    logic por_start;
    logic por_busy;
    logic por_done;
    logic [NUM_IRQ-1:0] pend;
    logic pg_rise;

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    rc_tick_div #(.DIV(RC_DIV)) u_div (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (rc_tick)
    );

    por_delay_timer #(.TICKS(POR_COUNT)) u_por (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (por_start),
        .rc_tick (rc_tick),
        .busy    (por_busy),
        .done    (por_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Delay triggers; stop recovery only counts while stopped
    assign pg_rise   = power_good && !s_q.pg_prev;
    assign por_start = pg_rise || watchdog_timeout
                     || (s_q.st == ST_STOP && stop_recovery && s_q.stop_recov[STOP_DELAY_BIT]);
    assign pend      = s_q.irq_flags[NUM_IRQ-1:0] & s_q.int_mask[NUM_IRQ-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.pg_prev     = power_good;
        s_d.int_take    = 1'b0;
        s_d.restart_req = 1'b0;
        s_d.rdata       = '0;

        // Requests latch in every state, halt included; set beats clear
        s_d.irq_flags[NUM_IRQ-1:0] = s_q.irq_flags[NUM_IRQ-1:0];
        if (reg_wr && reg_addr == ADDR_IRQ_FLAGS) begin
            s_d.irq_flags = reg_wdata;
        end
        s_d.irq_flags[NUM_IRQ-1:0] = s_d.irq_flags[NUM_IRQ-1:0] | irq_in;

        // Mask bits by write; global enable only by instructions
        if (reg_wr && reg_addr == ADDR_INT_MASK) begin
            s_d.int_mask[MASK_GLOBAL_BIT-1:0] = reg_wdata[MASK_GLOBAL_BIT-1:0];
        end
        if (enable_ints_instr) s_d.int_mask[MASK_GLOBAL_BIT] = 1'b1;
        if (disable_ints_instr) s_d.int_mask[MASK_GLOBAL_BIT] = 1'b0;
        if (reg_wr && reg_addr == ADDR_STOP_RECOV) s_d.stop_recov = reg_wdata;

        // Read port, unmapped addresses return zero
        if (reg_rd) begin
            case (reg_addr)
                ADDR_IRQ_FLAGS:  s_d.rdata = s_q.irq_flags;
                ADDR_INT_MASK:   s_d.rdata = s_q.int_mask;
                ADDR_STOP_RECOV: s_d.rdata = s_q.stop_recov;
                ADDR_PWR_STATUS: s_d.rdata = {5'h00, s_q.st == ST_STOP, s_q.st == ST_HALT, por_busy};
                default:         s_d.rdata = '0;
            endcase
        end

        // Interrupt taken: acknowledged source flag clears
        if (int_ack) begin
            s_d.irq_flags[s_q.int_vector] = irq_in[s_q.int_vector];
        end

        case (s_q.st)
            ST_DELAY: begin
                s_d.cpu_reset     = 1'b1;
                s_d.cpu_clk_en    = 1'b0;
                s_d.xtal_en       = 1'b1;
                s_d.periph_clk_en = 1'b1;
                if (por_done && !por_start) begin
                    s_d.st          = ST_RUN;
                    s_d.cpu_reset   = 1'b0;
                    s_d.cpu_clk_en  = 1'b1;
                    s_d.restart_req = 1'b1;
                end
            end
            ST_RUN: begin
                if (s_q.int_mask[MASK_GLOBAL_BIT] && |pend) begin
                    s_d.int_take   = 1'b1;
                    s_d.int_vector = pick_irq(pend);
                end
                if (stop_instr) begin
                    s_d.st            = ST_STOP;
                    s_d.cpu_clk_en    = 1'b0;
                    s_d.xtal_en       = 1'b0;
                    s_d.periph_clk_en = 1'b0;
                end else if (halt_instr) begin
                    s_d.st         = ST_HALT;
                    s_d.cpu_clk_en = 1'b0;
                    s_d.int_take   = 1'b0;
                end
            end
            ST_HALT: begin
                // Only an enabled request wakes; return goes to the next instruction
                if (s_q.int_mask[MASK_GLOBAL_BIT] && |pend) begin
                    s_d.st         = ST_RUN;
                    s_d.cpu_clk_en = 1'b1;
                    s_d.int_take   = 1'b1;
                    s_d.int_vector = pick_irq(pend);
                end
            end
            ST_STOP: begin
                // Recovery without the delay restarts straight away
                if (stop_recovery && !s_q.stop_recov[STOP_DELAY_BIT]) begin
                    s_d.st            = ST_RUN;
                    s_d.xtal_en       = 1'b1;
                    s_d.periph_clk_en = 1'b1;
                    s_d.cpu_clk_en    = 1'b1;
                    s_d.restart_req   = 1'b1;
                end else if (ext_reset) begin
                    s_d.st            = ST_RUN;
                    s_d.xtal_en       = 1'b1;
                    s_d.periph_clk_en = 1'b1;
                    s_d.cpu_clk_en    = 1'b1;
                    s_d.restart_req   = 1'b1;
                end
            end
            default: s_d.st = ST_DELAY;
        endcase

        // Any delay trigger forces the delay state, overriding the above
        if (por_start) begin
            s_d.st            = ST_DELAY;
            s_d.cpu_reset     = 1'b1;
            s_d.cpu_clk_en    = 1'b0;
            s_d.xtal_en       = 1'b1;
            s_d.periph_clk_en = 1'b1;
            s_d.int_take      = 1'b0;
            s_d.restart_req   = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset enters the delay, processor held off
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q               <= '0;
            s_q.irq_flags     <= IRQ_FLAGS_RESET;
            s_q.int_mask      <= INT_MASK_RESET;
            s_q.stop_recov    <= STOP_RECOV_RESET;
            s_q.st            <= ST_DELAY;
            s_q.cpu_reset     <= 1'b1;
            s_q.xtal_en       <= 1'b1;
            s_q.periph_clk_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops, except restart_addr, which is the constant RESTART_ADDR
    assign reg_rdata     = s_q.rdata;
    assign cpu_reset     = s_q.cpu_reset;
    assign cpu_clk_en    = s_q.cpu_clk_en;
    assign xtal_en       = s_q.xtal_en;
    assign periph_clk_en = s_q.periph_clk_en;
    assign int_take      = s_q.int_take;
    assign int_vector    = s_q.int_vector;
    assign restart_req   = s_q.restart_req;
    assign restart_addr  = RESTART_ADDR;
endmodule

// ---- src/pwr_seq_pkg.sv ----
// Purpose : Shared constants for the power-up delay, halt and stop sequencer
// Assumes : One 40 MHz system clock; RC oscillator tick arrives as an enable pulse
// Notes   : Register offsets are byte addresses on the plain register port
//
// Overview of operation
// - Power-up delay is a one-shot timer advanced only by RC oscillator ticks.
// - Delay starts on power-good rise, watchdog timeout, or stop recovery with bit 5 set.
// - Delay lasts at least 2.5 ms before execution is released; tick phase can cut up to one RC tick off this.
// - Stop-recovery register bit 5 applies or skips the delay after stop recovery.
// - Halt gates the processor clock; crystal oscillator keeps running.
// - In halt, timers and six external interrupt inputs still raise requests.
// - Halt ends on an enabled interrupt, execution resuming after halt, or on a watchdog timeout or power-good rise.
// - Stop shuts off processor clock and crystal oscillator.
// - Stop ends only through a reset source; restart at address 000CH.
package pwr_seq_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  ADDR_IRQ_FLAGS   = 8'hfa;
    localparam logic [7:0]  ADDR_INT_MASK    = 8'hfb;
    localparam logic [7:0]  ADDR_STOP_RECOV  = 8'h0b;
    localparam logic [7:0]  ADDR_PWR_STATUS  = 8'h0c;
    localparam logic [7:0]  IRQ_FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  INT_MASK_RESET   = 8'h00;
    localparam logic [7:0]  STOP_RECOV_RESET = 8'h20;
    localparam int          STOP_DELAY_BIT   = 5;
    localparam int          MASK_GLOBAL_BIT  = 7;
    localparam int          NUM_IRQ          = 6;
    localparam logic [15:0] RESTART_ADDR     = 16'h000c;
    localparam real         POR_MIN_MS       = 2.5;
    localparam real         RC_FREQ_KHZ      = 32.0;
    // Least time rounds up to whole RC ticks
    localparam int          POR_TICKS        = int'($ceil(POR_MIN_MS * RC_FREQ_KHZ));
    typedef enum logic [2:0] {ST_DELAY, ST_RUN, ST_HALT, ST_STOP} pwr_state_t;
endpackage

// ---- src/rc_tick_div.sv ----
// Purpose : Makes the RC oscillator tick enable from the system clock
// Assumes : Divider stands in for the dedicated RC oscillator
// Notes   : Runs even in stop, as the RC oscillator does
`timescale 1ns/1ps
module rc_tick_div #(
    parameter int DIV = 1250
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } div_t;
    div_t s_q, s_d;

    initial if (DIV < 1 || DIV > 65535) $error("DIV out of range");

    // Count down, pulse once per period
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 16'h0000) begin
            s_d.cnt  = 16'(DIV - 1);
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) s_q <= '0;
        else s_q <= s_d;
    end
    assign tick = s_q.tick;
endmodule

// ---- src/por_delay_timer.sv ----
// Purpose : One-shot power-up delay counter on RC ticks
// Assumes : start is a one-cycle pulse; rc_tick an enable
// Notes   : A new start retriggers the full delay
`timescale 1ns/1ps
module por_delay_timer #(
    parameter int TICKS = 80
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic start,
    input  wire logic rc_tick,
    output logic      busy,
    output logic      done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        done;
    } tmr_t;
    tmr_t s_q, s_d;

    initial if (TICKS < 1 || TICKS > 65535) $error("TICKS out of range");

    // One-shot: load on start, count only on RC ticks
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.cnt  = 16'(TICKS);
            s_d.busy = 1'b1;
        end else if (s_q.busy && rc_tick) begin
            if (s_q.cnt == 16'h0001) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    // Busy from reset so power-on counts as a power-good rise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q.cnt  <= 16'(TICKS);
            s_q.busy <= 1'b1;
            s_q.done <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end
    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// ---- verif/pwr_seq_properties.sv ----
// Purpose : Port-level checks of the power-up delay, halt and stop sequencer
// Assumes : Single clock domain, synchronous active-low reset
// Notes   : Delay bounds follow the RC_DIV and POR_COUNT handed down by the bind
`timescale 1ns/1ps
module pwr_seq_properties #(
    parameter int RC_DIV    = 2,
    parameter int POR_COUNT = 3
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        watchdog_timeout,
    input wire logic        stop_recovery,
    input wire logic        ext_reset,
    input wire logic        power_good,
    input wire logic        halt_instr,
    input wire logic        stop_instr,
    input wire logic        cpu_reset,
    input wire logic        cpu_clk_en,
    input wire logic        xtal_en,
    input wire logic        periph_clk_en,
    input wire logic        int_take,
    input wire logic        restart_req,
    input wire logic [15:0] restart_addr
);
    // Tick phase may shave up to one tick off the nominal count
    localparam int MIN_HOLD = (POR_COUNT - 1) * RC_DIV;
    localparam int MAX_HOLD = (POR_COUNT + 2) * RC_DIV + 4;
    logic [15:0] hold_q;
    logic        pg_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Counts the hold since the latest delay trigger; a retrigger legally lengthens the hold
    always_ff @(posedge clk) begin
        pg_q <= reset_n && power_good;
        if (!reset_n || !cpu_reset || watchdog_timeout || (power_good && !pg_q)) hold_q <= 16'h0000;
        else hold_q <= hold_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock gating on entry to the low-power states
    property p_halt_gate; halt_instr && !stop_instr && cpu_clk_en |=> !cpu_clk_en && xtal_en; endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("halt did not gate only the cpu clock");
    // A delay trigger in the same cycle rightly keeps the crystal running
    property p_stop_off;
        stop_instr && cpu_clk_en && !watchdog_timeout && !$rose(power_good)
            |=> !cpu_clk_en && !xtal_en && !periph_clk_en;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop left a clock running");
    property p_halt_periph; !cpu_clk_en && xtal_en |-> periph_clk_en; endproperty
    a_halt_periph: assert property (p_halt_periph) else $error("peripherals stopped in halt");
    // Wake from halt only with a taken interrupt
    property p_halt_wake; $rose(cpu_clk_en) && $past(xtal_en) && !$past(cpu_reset) |-> int_take; endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt left without interrupt");
    // Stop holds until a reset source arrives; interrupts cannot wake it
    property p_stop_hold;
        !xtal_en && !stop_recovery && !ext_reset && !watchdog_timeout && !$rose(power_good) |=> !xtal_en;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset source");
    // Delay start, length and release
    property p_wdt_start; watchdog_timeout |=> cpu_reset; endproperty
    a_wdt_start: assert property (p_wdt_start) else $error("watchdog did not start delay");
    property p_delay_min; $fell(cpu_reset) |-> hold_q >= MIN_HOLD; endproperty
    a_delay_min: assert property (p_delay_min) else $error("delay released too early");
    property p_delay_max; cpu_reset |-> hold_q < MAX_HOLD; endproperty
    a_delay_max: assert property (p_delay_max) else $error("delay held too long");
    property p_release; $fell(cpu_reset) |-> restart_req && cpu_clk_en && restart_addr == 16'h000c; endproperty
    a_release: assert property (p_release) else $error("release without restart");

    c_halt_wake: cover property (int_take && cpu_clk_en);
    c_stop: cover property (!xtal_en);
    c_release: cover property ($fell(cpu_reset));
endmodule

bind pwr_seq_ctrl pwr_seq_properties #(.RC_DIV(RC_DIV), .POR_COUNT(POR_COUNT)) chk (.clk, .reset_n,
    .watchdog_timeout, .stop_recovery, .ext_reset, .power_good, .halt_instr, .stop_instr, .cpu_reset,
    .cpu_clk_en, .xtal_en, .periph_clk_en, .int_take, .restart_req, .restart_addr);

// ---- verif/tb.sv ----
// Purpose : Self-checking bench for the sequencer
// Assumes : Short delay parameters keep the run brief
// Notes   : Pulse inputs travel in one vector, one bit per source
`timescale 1ns/1ps
module tb;
    import pwr_seq_pkg::*;
    localparam int RD = 2;
    localparam int PC = 3;
    localparam int MIN = (PC - 1) * RD;
    localparam logic [13:0] WDOG = 14'h2000, SRC = 14'h1000, EXR = 14'h0800, HLT = 14'h0400;
    localparam logic [13:0] STP = 14'h0200, INT_ON = 14'h0100, INT_OFF = 14'h0080, ACK = 14'h0040;
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} row_t;
    row_t rows [11] = '{'{1'b0, ADDR_IRQ_FLAGS, IRQ_FLAGS_RESET}, '{1'b0, ADDR_INT_MASK, INT_MASK_RESET},
        '{1'b0, ADDR_STOP_RECOV, STOP_RECOV_RESET}, '{1'b1, ADDR_INT_MASK, 8'hbf},
        '{1'b0, ADDR_INT_MASK, 8'h3f}, '{1'b1, ADDR_IRQ_FLAGS, 8'h05}, '{1'b0, ADDR_IRQ_FLAGS, 8'h05},
        '{1'b1, ADDR_IRQ_FLAGS, 8'h00}, '{1'b1, 8'h40, 8'h5a}, '{1'b0, 8'h40, 8'h00},
        '{1'b0, ADDR_PWR_STATUS, 8'h00}};
    logic        clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, power_good = 1, saw;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [13:0] pin = '0;
    logic        cpu_reset, cpu_clk_en, xtal_en, periph_clk_en, int_take, restart_req;
    logic [2:0]  int_vector;
    logic [15:0] restart_addr;
    int          fail_count = 0, checked = 0, n;

    pwr_seq_ctrl #(.RC_DIV(RD), .POR_COUNT(PC)) DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_good(power_good), .watchdog_timeout(pin[13]), .stop_recovery(pin[12]), .ext_reset(pin[11]),
        .irq_in(pin[5:0]), .halt_instr(pin[10]), .stop_instr(pin[9]), .enable_ints_instr(pin[8]),
        .disable_ints_instr(pin[7]), .int_ack(pin[6]), .cpu_reset(cpu_reset), .cpu_clk_en(cpu_clk_en),
        .xtal_en(xtal_en), .periph_clk_en(periph_clk_en), .int_take(int_take), .int_vector(int_vector),
        .restart_req(restart_req), .restart_addr(restart_addr));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One-cycle pulse; returns just after the edge that took it
    // The idle edge ahead of each pulse stands for the flushing no-op before halt or stop
    task pulse(input logic [13:0] v);
        @(posedge clk);
        pin <= v;
        @(posedge clk);
        pin <= '0;
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Bounded wait for the restart pulse, noting any reset hold on the way
    task wait_go;
        n = 0;
        saw = cpu_reset;
        while (restart_req !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
            saw |= cpu_reset;
        end
        check(n < 40, 1'b1);
    endtask

    task wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog on the whole run; far beyond the fewer than two hundred cycles needed
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        test_done;
    end

    initial begin
        wait_cyc(10);
        check({cpu_reset, cpu_clk_en, xtal_en}, 3'b101);
        @(posedge clk);
        reset_n <= 1'b1;
        wait_go;
        check(n >= MIN, 1'b1);
        check(restart_addr, RESTART_ADDR);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a, d);
                check(d, rows[i].d);
            end
        end
        pulse(WDOG);
        check(cpu_reset, 1'b1);
        wait_go;
        check(n >= MIN, 1'b1);
        // Halt: a masked request must not wake, an enabled one must
        wr(ADDR_INT_MASK, 8'h04);
        pulse(INT_ON);
        pulse(HLT);
        check({cpu_clk_en, xtal_en, periph_clk_en}, 3'b011);
        pulse(14'h0008);
        wait_cyc(6);
        check(cpu_clk_en, 1'b0);
        rd(ADDR_PWR_STATUS, d);
        check(d, 8'h02);
        pulse(14'h0004);
        n = 0;
        while (int_take !== 1'b1 && n < 8) begin
            wait_cyc(1);
            n++;
        end
        check({cpu_clk_en, int_take, int_vector}, 5'b11010);
        rd(ADDR_IRQ_FLAGS, d);
        check(d, 8'h0c);
        pulse(ACK);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        // Timer mode stays fixed here, so no timer disable is owed
        // Stop with delay skipped; a request must not end it
        wr(ADDR_STOP_RECOV, 8'h00);
        pulse(STP);
        check({cpu_clk_en, xtal_en, periph_clk_en}, 3'b000);
        pulse(14'h0004);
        wait_cyc(6);
        check(xtal_en, 1'b0);
        rd(ADDR_PWR_STATUS, d);
        check(d, 8'h04);
        pulse(SRC);
        wait_go;
        check(saw, 1'b0);
        pulse(INT_OFF);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        // Stop with delay applied, then stop ended by external reset with no delay
        wr(ADDR_STOP_RECOV, 8'h20);
        pulse(STP);
        pulse(SRC);
        check(cpu_reset, 1'b1);
        wait_go;
        check(n >= MIN, 1'b1);
        pulse(STP);
        pulse(EXR);
        wait_go;
        check(saw, 1'b0);
        check(restart_addr, RESTART_ADDR);
        // Supply dip and recovery
        @(posedge clk);
        power_good <= 1'b0;
        @(posedge clk);
        power_good <= 1'b1;
        wait_cyc(1);
        check(cpu_reset, 1'b1);
        wait_go;
        // Reset in the middle of a running delay
        pulse(WDOG);
        @(posedge clk);
        reset_n <= 1'b0;
        wait_cyc(2);
        check(cpu_reset, 1'b1);
        @(posedge clk);
        reset_n <= 1'b1;
        wait_go;
        check(n >= MIN, 1'b1);
        test_done;
    end
endmodule
